// file: rtl/caw_pkg.sv
/*
  Package for the counter array watchdog: register offsets, field positions,
  reset values and timing constants.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
package caw_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'h08;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_OFFSET   = 8'h10;
  localparam logic [7:0] ADDR_COMPARE  = 8'h14;
  localparam logic [7:0] ADDR_M5_MODE  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // counter_mode_reg
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_EN_BIT   = 6;
  localparam int MODE_LOCK_BIT = 5;
  localparam int MODE_CSEL_LSB = 1;
  localparam int CSEL_W        = 3;
  // counter_control_reg
  localparam int CTRL_RUN_BIT  = 6;
  localparam int CTRL_M5_BIT   = 5;
  // Interrupt status bits
  localparam int IRQ_TIMEOUT   = 0;
  localparam int IRQ_FORCED    = 1;
  localparam int IRQ_W         = 2;

  // ----------------------------------------------------------------
  // Clock select codes, byte limits and reset values
  // ----------------------------------------------------------------
  localparam logic [CSEL_W-1:0] CSEL_DIV12 = 3'h0;
  localparam logic [CSEL_W-1:0] CSEL_DIV4  = 3'h1;
  localparam logic [CSEL_W-1:0] CSEL_SYS   = 3'h4;
  localparam logic [CSEL_W-1:0] CSEL_EXT   = 3'h2;
  localparam logic [7:0]        BYTE_ZERO  = 8'h00;
  localparam logic [7:0]        BYTE_MAX   = 8'hFF;
  localparam logic [7:0]        M5_MODE_RST = 8'h49;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int  DIV12   = 12;
  localparam int  DIV4    = 4;
  localparam logic [3:0] PRE_LAST12 = 4'(DIV12 - 1);
  localparam logic [3:0] PRE_LAST4  = 4'(DIV4 - 1);
  localparam logic [3:0] PRE_ZERO   = 4'h0;
endpackage

// file: rtl/caw_watchdog.sv
/*
  Counter array watchdog: 16-bit counter, module five as watchdog compare,
  Wishbone register slave, sticky interrupt status and a reset request.
  Assumes the chip reset logic answers the one-cycle reset request by
  asserting ARST_N_IN; idle and external tick inputs come from other clock
  sources and are synchronised here.
*/
// Overview of operation
// - Timeout is 256 times offset plus 256 minus low
// - Reset on low overflow while compare equals high
// - Writing one to match flag forces reset while enabled
// - Idle-suspend halts counting during processor idle
// - Clock source and idle choice frozen while enabled
// - Enable bit or lock bit enables watchdog
// - Lock keeps watchdog enabled until reset
// - Unlocked, clearing enable disables watchdog
// - Watchdog comes up enabled after reset
// - Defaults: divide by twelve, low and offset zero
// - Defaults expire after 3072 system clocks
// - Enabled, compare write loads high byte plus offset
// - Enabled: counter runs, byte and mode writes ignored
// - Enabled: run bit cannot stop counter; reads software value
`timescale 1ns/1ps
module caw_watchdog
  import caw_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        ARST_N_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Processor state and external tick
  input  wire logic        CPU_IDLE_IN,
  input  wire logic        EXT_TICK_IN,
  // Results
  output logic             WDT_RESET_REQ_OUT,
  output logic             IRQ_OUT
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] idle_sync;
  logic [2:0] ext_sync;
  logic       idle_s;
  logic       ext_rise;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idle_sync <= 2'h0;
      ext_sync  <= 3'h0;
    end else begin
      idle_sync <= {idle_sync[0], CPU_IDLE_IN};
      ext_sync  <= {ext_sync[1:0], EXT_TICK_IN};
    end
  end

  assign idle_s   = idle_sync[1];
  assign ext_rise = ext_sync[1] & ~ext_sync[2];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wb_req;
  logic wr;
  logic rd_ack;

  assign wb_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  assign wr     = wb_req & WB_WE_IN & WB_SEL_IN[0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Mode and control registers
  // ----------------------------------------------------------------
  logic              wdt_enable_bit;
  logic              wdt_lock_bit;
  logic              idle_suspend_bit;
  logic [CSEL_W-1:0] counter_clock_select;
  logic              counter_run_bit;
  logic              wdt_on;
  logic [7:0]        wdat;

  assign wdat   = WB_DAT_IN[7:0];
  assign wdt_on = wdt_enable_bit | wdt_lock_bit;

  // Enable sets at reset; lock can only be set, reset clears it
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wdt_enable_bit <= 1'b1;
      wdt_lock_bit   <= 1'b0;
    end else if (wr && hit(WB_ADR_IN, ADDR_MODE)) begin
      wdt_enable_bit <= wdat[MODE_EN_BIT];
      wdt_lock_bit   <= wdt_lock_bit | wdat[MODE_LOCK_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      counter_clock_select <= CSEL_DIV12;
      idle_suspend_bit     <= 1'b0;
    end else if (wr && hit(WB_ADR_IN, ADDR_MODE) && !wdt_on) begin
      counter_clock_select <= wdat[MODE_CSEL_LSB +: CSEL_W];
      idle_suspend_bit     <= wdat[MODE_IDLE_BIT];
    end
  end

  // Stored run bit reads back as written, regardless of forced running
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      counter_run_bit <= 1'b0;
    end else if (wr && hit(WB_ADR_IN, ADDR_CONTROL)) begin
      counter_run_bit <= wdat[CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Counter clock prescaler
  // ----------------------------------------------------------------
  logic [3:0] pre_cnt;
  logic [3:0] pre_last;
  logic       tick;
  logic       count_en;

  assign count_en = (wdt_on | counter_run_bit)
                  & ~(idle_suspend_bit & idle_s);

  always_comb begin
    pre_last = PRE_LAST12;
    case (counter_clock_select)
      CSEL_DIV12: pre_last = PRE_LAST12;
      CSEL_DIV4:  pre_last = PRE_LAST4;
      default:    pre_last = PRE_ZERO;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pre_cnt <= PRE_ZERO;
    end else if (count_en) begin
      pre_cnt <= (pre_cnt >= pre_last) ? PRE_ZERO : pre_cnt + 4'h1;
    end
  end

  // One counter tick per divide period; external source uses its rising edges
  always_comb begin
    case (counter_clock_select)
      CSEL_EXT: tick = count_en & ext_rise;
      CSEL_SYS: tick = count_en;
      default:  tick = count_en & (pre_cnt >= pre_last);
    endcase
  end

  // ----------------------------------------------------------------
  // Counter bytes
  // ----------------------------------------------------------------
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic       low_wrap;

  assign low_wrap = tick & (counter_low_byte == BYTE_MAX);

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      counter_low_byte <= BYTE_ZERO;
    end else if (wr && hit(WB_ADR_IN, ADDR_CNT_LOW) && !wdt_on) begin
      counter_low_byte <= wdat;
    end else if (tick) begin
      counter_low_byte <= counter_low_byte + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      counter_high_byte <= BYTE_ZERO;
    end else if (wr && hit(WB_ADR_IN, ADDR_CNT_HIGH) && !wdt_on) begin
      counter_high_byte <= wdat;
    end else if (low_wrap) begin
      counter_high_byte <= counter_high_byte + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Module five: offset, compare, mode
  // ----------------------------------------------------------------
  logic [7:0] wdt_offset_reg;
  logic [7:0] wdt_compare_reg;
  logic [7:0] module_five_mode_reg;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wdt_offset_reg <= BYTE_ZERO;
    end else if (wr && hit(WB_ADR_IN, ADDR_OFFSET)) begin
      wdt_offset_reg <= wdat;
    end
  end

  // Any write refreshes while enabled; plain load otherwise
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wdt_compare_reg <= BYTE_ZERO;
    end else if (wr && hit(WB_ADR_IN, ADDR_COMPARE)) begin
      wdt_compare_reg <= wdt_on ? counter_high_byte + wdt_offset_reg
                                : wdat;
    end
  end

  // Mode register holds its value; software writes ignored while enabled
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      module_five_mode_reg <= M5_MODE_RST;
    end else if (wr && hit(WB_ADR_IN, ADDR_M5_MODE) && !wdt_on) begin
      module_five_mode_reg <= wdat;
    end
  end

  // ----------------------------------------------------------------
  // Reset causes and request
  // ----------------------------------------------------------------
  logic timeout;
  logic forced;

  // Compare of high bytes; expiry on the low-byte wrap
  assign timeout = wdt_on & low_wrap & (wdt_compare_reg == counter_high_byte);
  assign forced  = wdt_on & wr & hit(WB_ADR_IN, ADDR_CONTROL) & wdat[CTRL_M5_BIT];

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WDT_RESET_REQ_OUT <= 1'b0;
    end else begin
      WDT_RESET_REQ_OUT <= timeout | forced;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_evt = {forced, timeout};
  assign irq_clr = (wr && hit(WB_ADR_IN, ADDR_IRQ_CLR)) ? wdat[IRQ_W-1:0] : '0;

  // Set beats clear in the same cycle
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_en <= '0;
    end else if (wr && hit(WB_ADR_IN, ADDR_IRQ_EN)) begin
      irq_en <= wdat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = BYTE_ZERO;
    case (WB_ADR_IN)
      ADDR_MODE:     next_rdata = {idle_suspend_bit, wdt_enable_bit, wdt_lock_bit,
                                   1'b0, counter_clock_select, 1'b0};
      ADDR_CONTROL:  next_rdata = {1'b0, counter_run_bit, 6'h00};
      ADDR_CNT_LOW:  next_rdata = counter_low_byte;
      ADDR_CNT_HIGH: next_rdata = counter_high_byte;
      ADDR_OFFSET:   next_rdata = wdt_offset_reg;
      ADDR_COMPARE:  next_rdata = wdt_compare_reg;
      ADDR_M5_MODE:  next_rdata = module_five_mode_reg;
      ADDR_IRQ_STAT: next_rdata = {6'h00, irq_stat};
      ADDR_IRQ_EN:   next_rdata = {6'h00, irq_en};
      default:       next_rdata = BYTE_ZERO;
    endcase
  end

  assign rd_ack = wb_req;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= rd_ack;
      WB_DAT_OUT <= rd_ack ? {24'h00_0000, next_rdata} : 32'h0000_0000;
    end
  end

endmodule

// file: test/caw_watchdog_properties.sv
/* Port checker for caw_watchdog.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module caw_watchdog_chk
  import caw_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS_IN,
  input wire logic        ARST_N_IN,
  // Wishbone
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  // Misc
  input wire logic        CPU_IDLE_IN,
  input wire logic        EXT_TICK_IN,
  input wire logic        WDT_RESET_REQ_OUT,
  input wire logic        IRQ_OUT
);
  // ----------------------------------------
  // Shadow of enable and interrupt enables
  // ----------------------------------------
  logic       req_t;
  logic       wr_t;
  logic       en_m;
  logic       lk_m;
  logic [1:0] ien_m;
  assign req_t = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign wr_t  = req_t && WB_WE_IN && WB_SEL_IN[0];
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      en_m <= 1'b1;
      lk_m <= 1'b0;
    end else if (wr_t && WB_ADR_IN == ADDR_MODE) begin
      lk_m <= lk_m | WB_DAT_IN[MODE_LOCK_BIT];
      en_m <= lk_m | WB_DAT_IN[MODE_LOCK_BIT] | WB_DAT_IN[MODE_EN_BIT];
    end
  end
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ien_m <= 2'h0;
    end else if (wr_t && WB_ADR_IN == ADDR_IRQ_EN) begin
      ien_m <= WB_DAT_IN[1:0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  AST_ACK_NEXT: assert property (req_t |=> WB_ACK_OUT)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (!req_t |=> !WB_ACK_OUT)
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("read data outside ack");
  AST_DAT_UPPER: assert property (WB_DAT_OUT[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_REQ_PULSE: assert property (WDT_RESET_REQ_OUT |=> !WDT_RESET_REQ_OUT)
    else $error("reset request longer than one cycle");
  AST_FORCE: assert property (wr_t && WB_ADR_IN == ADDR_CONTROL && WB_DAT_IN[CTRL_M5_BIT]
    && en_m |=> WDT_RESET_REQ_OUT)
    else $error("forced reset missing");
  AST_IRQ_RAISE: assert property (WDT_RESET_REQ_OUT && ien_m == 2'h3 |-> ##[0:2] IRQ_OUT)
    else $error("interrupt not raised");
  AST_CLR_READ: assert property (req_t && !WB_WE_IN && WB_ADR_IN == ADDR_IRQ_CLR
    |=> WB_DAT_OUT == 32'h0)
    else $error("clear register reads nonzero");
  COV_FORCE: cover property (wr_t && WB_ADR_IN == ADDR_CONTROL ##1 WDT_RESET_REQ_OUT);
  COV_IRQ: cover property ($rose(IRQ_OUT));
  COV_LOCK: cover property (lk_m && WDT_RESET_REQ_OUT);
endmodule
bind caw_watchdog caw_watchdog_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .CPU_IDLE_IN(CPU_IDLE_IN), .EXT_TICK_IN(EXT_TICK_IN),
  .WDT_RESET_REQ_OUT(WDT_RESET_REQ_OUT), .IRQ_OUT(IRQ_OUT));

// file: test/caw_watchdog_bench.sv
/* Self-checking bench for caw_watchdog.
   Assumes the bench plays the chip reset logic and the Wishbone master. */
`timescale 1ns/1ps
module caw_watchdog_bench
  import caw_pkg::*;
;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic        idle  = 1'b0;
  logic        tick  = 1'b0;
  logic [31:0] dat_r;
  logic        ack;
  logic        req;
  logic        irq;
  logic [31:0] seed  = 32'hC8044C06;
  logic [31:0] tseed = 32'hC8044C06;
  logic [31:0] a;
  logic [31:0] b;
  int          n_fail = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  int          l;
  int          o;
  realtime     t0;

  caw_watchdog u_dut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r),
    .WB_ACK_OUT(ack), .CPU_IDLE_IN(idle), .EXT_TICK_IN(tick), .WDT_RESET_REQ_OUT(req),
    .IRQ_OUT(irq));

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic int exp_to(input int off, input int low);
    return 256 * off + 256 - low;
  endfunction
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= ad;
    dat_w <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    a = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e, input string what);
    acc(1'b0, ad, 8'h00);
    chk(a, {24'h0, e}, what);
  endtask
  task automatic wait_req();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req !== 1'b1 && n < 6000);
  endtask
  task automatic hw_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Free-running random external tick and hang guard
  always @(posedge clk) begin
    tseed <= xs(tseed);
    tick  <= tseed[7];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    hw_reset();
    wait_req();
    chk(n >= 3072 && n <= 3080, 1, "default timeout");
    hw_reset();
    rdc(ADDR_MODE, 8'h40, "mode after reset");
    rdc(ADDR_OFFSET, 8'h00, "offset reset");
    rdc(ADDR_CONTROL, 8'h00, "run bit reads zero");
    acc(1'b1, ADDR_MODE, 8'h48);
    rdc(ADDR_MODE, 8'h40, "clock select frozen");
    acc(1'b1, ADDR_CNT_HIGH, 8'h55);
    rdc(ADDR_CNT_HIGH, 8'h00, "high byte write ignored");
    acc(1'b1, ADDR_M5_MODE, 8'h00);
    rdc(ADDR_M5_MODE, 8'h49, "module five mode locked");
    rdc(8'h30, 8'h00, "unmapped read");
    acc(1'b0, ADDR_CNT_LOW, 8'h00);
    b = a;
    repeat (30) @(posedge clk);
    acc(1'b0, ADDR_CNT_LOW, 8'h00);
    chk(a == b, 0, "counter forced on");
    // Lock, interrupt raise, clear and mask
    hw_reset();
    acc(1'b1, ADDR_IRQ_EN, 8'h03);
    acc(1'b1, ADDR_MODE, 8'h20);
    acc(1'b1, ADDR_MODE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, ADDR_CONTROL, 8'h20);
      chk(req, 1, "forced reset under lock");
      repeat (2) @(posedge clk);
      chk(irq, i == 0, "interrupt level");
      rdc(ADDR_IRQ_STAT, 8'h02, "forced status");
      acc(1'b1, ADDR_IRQ_CLR, 8'h02);
      @(posedge clk);
      chk(irq, 0, "interrupt cleared");
      rdc(ADDR_IRQ_CLR, 8'h00, "clear register reads zero");
      acc(1'b1, ADDR_IRQ_EN, 8'h00);
    end
    // Programmed timeout from random offset and low byte
    repeat (2) begin
      seed = xs(seed);
      l = int'(seed[6:0]);
      o = 1 + int'(seed[9:8]) % 3;
      hw_reset();
      acc(1'b1, ADDR_MODE, 8'h00);
      rdc(ADDR_MODE, 8'h00, "disabled");
      acc(1'b1, ADDR_CONTROL, 8'h20);
      chk(req, 0, "no force when off");
      repeat (4) begin
        @(posedge clk);
        chk(req, 0, "no force when off");
      end
      acc(1'b1, ADDR_MODE, 8'h08);
      acc(1'b1, ADDR_CNT_LOW, l[7:0]);
      acc(1'b1, ADDR_OFFSET, o[7:0]);
      acc(1'b1, ADDR_COMPARE, 8'h00);
      acc(1'b1, ADDR_MODE, 8'h48);
      t0 = $realtime;
      acc(1'b1, ADDR_COMPARE, 8'hA5);
      rdc(ADDR_COMPARE, o[7:0], "refresh loads high plus offset");
      wait_req();
      n = int'(($realtime - t0) / 5.0);
      chk(n >= exp_to(o, l) - 2 && n <= exp_to(o, l) + 4, 1, "programmed timeout");
    end
    // Divide-by-four and external tick sources
    for (int m = 0; m < 2; m++) begin
      hw_reset();
      acc(1'b1, ADDR_MODE, 8'h00);
      acc(1'b1, ADDR_MODE, m == 0 ? 8'h02 : 8'h04);
      acc(1'b1, ADDR_MODE, m == 0 ? 8'h42 : 8'h44);
      rdc(ADDR_MODE, m == 0 ? 8'h42 : 8'h44, "clock source chosen");
      acc(1'b0, ADDR_CNT_LOW, 8'h00);
      b = a;
      repeat (40) @(posedge clk);
      acc(1'b0, ADDR_CNT_LOW, 8'h00);
      chk(a - b >= (m == 0 ? 10 : 1) && a - b <= (m == 0 ? 11 : 22), 1, "source rate");
    end
    // Idle suspend halts the count
    hw_reset();
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_MODE, 8'h88);
    acc(1'b1, ADDR_MODE, 8'hC8);
    idle <= 1'b1;
    repeat (8) @(posedge clk);
    acc(1'b0, ADDR_CNT_LOW, 8'h00);
    b = a;
    repeat (20) @(posedge clk);
    acc(1'b0, ADDR_CNT_LOW, 8'h00);
    chk(a, b, "count held in idle");
    idle <= 1'b0;
    repeat (20) @(posedge clk);
    acc(1'b0, ADDR_CNT_LOW, 8'h00);
    chk(a == b, 0, "count resumes");
    stop_test();
  end
endmodule
